// file: hdl/ccs_pkg.sv
// constants and types for the contactor coil stage sequencer
// assumes one 250 MHz core clock and digitized comparator inputs
`default_nettype none
package ccs_pkg;
  localparam int unsigned CLK_KHZ = 250000;
  localparam int unsigned UV_DEBOUNCE_US = 2000;
  localparam int unsigned FS_DETECT_US = 660;
  localparam int unsigned STAGE_DELAY_MS = 98;
  localparam int unsigned FS_SINK_MS = 98;
  localparam int unsigned SW_FREQ_HZ = 23500;
  localparam int unsigned JITTER_PERMIL = 65;
  localparam int unsigned UV_CYC = UV_DEBOUNCE_US * (CLK_KHZ / 1000);
  localparam int unsigned FS_DET_CYC = FS_DETECT_US * (CLK_KHZ / 1000);
  localparam int unsigned STAGE_CYC = STAGE_DELAY_MS * CLK_KHZ;
  localparam int unsigned FS_SINK_CYC = FS_SINK_MS * CLK_KHZ;
  localparam int unsigned PERIOD_CYC = (CLK_KHZ * 1000) / SW_FREQ_HZ;
  localparam int unsigned JIT_SPAN_CYC = PERIOD_CYC * JITTER_PERMIL / 2000;
  localparam int unsigned TW = 25;
  localparam int unsigned PW = 14;
  localparam logic [PW-1:0] MIN_ON_CYC = 14'h0082;
  typedef enum logic [2:0] {
    CCS_ST_IDLE = 3'b000,
    CCS_ST_PICKUP = 3'b001,
    CCS_ST_HOLD = 3'b010,
    CCS_ST_UV = 3'b011
  } ccs_state_t;
endpackage : ccs_pkg
`default_nettype wire

// file: hdl/ccs_pwm_if.sv
// carrier between sequencer and pwm timebase
// assumes both ends in the core clock domain
`timescale 1ns/100ps
`default_nettype none
interface ccs_pwm_if;
  logic run;
  logic trip;
  logic gate_on;
  modport seq (output run, output trip, input gate_on);
  modport pwm (input run, input trip, output gate_on);
endinterface : ccs_pwm_if
`default_nettype wire

// file: hdl/ccs_pwm.sv
// peak-current pwm timebase with dithered period
// assumes trip is already stage-selected by the sequencer
`timescale 1ns/100ps
`default_nettype none
module ccs_pwm
  import ccs_pkg::*;
#(
  parameter logic [PW-1:0] PERIOD = PW'(PERIOD_CYC),
  parameter logic [PW-1:0] JSPAN = PW'(JIT_SPAN_CYC)
) (
  input wire logic clk,
  input wire logic nrst,
  ccs_pwm_if.pwm bus
);
  // ==========================================
  // period counter and triangle dither
  logic [PW-1:0] cnt_q, cnt_d;
  logic [PW-1:0] jit_q;
  logic jup_q;
  logic on_q;
  wire [PW-1:0] cur_period = PERIOD - JSPAN + (jit_q << 1);
  wire wrap = (cnt_q >= cur_period - PW'(1));
  wire min_done = (cnt_q >= MIN_ON_CYC);
  assign cnt_d = wrap ? '0 : cnt_q + PW'(1);
  always_ff @(posedge clk) begin
    if (!nrst || !bus.run) begin
      cnt_q <= '0;
      jit_q <= '0;
      jup_q <= 1'b1;
      on_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      if (wrap) begin
        jup_q <= (jit_q == JSPAN - PW'(1)) ? 1'b0 :
                 (jit_q == PW'(1)) ? 1'b1 : jup_q;
        jit_q <= jup_q ? jit_q + PW'(1) : jit_q - PW'(1);
      end
      if (wrap)
        on_q <= 1'b1;
      else if (bus.trip && min_done)
        on_q <= 1'b0;
    end
  end
  assign bus.gate_on = on_q;
endmodule : ccs_pwm
`default_nettype wire

// file: hdl/ccs_seq.sv
// contactor coil stage sequencer top
// assumes comparator results synchronous to clk, high = condition true
`timescale 1ns/100ps
`default_nettype none
module ccs_seq
  import ccs_pkg::*;
#(
  parameter int unsigned UV_N = UV_CYC,
  parameter int unsigned FS_DET_N = FS_DET_CYC,
  parameter int unsigned STAGE_N = STAGE_CYC,
  parameter int unsigned FS_SINK_N = FS_SINK_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic above_action_level,
  input wire logic below_release_level,
  input wire logic supply_on,
  input wire logic supply_off,
  input wire logic pickup_current_sense,
  input wire logic hold_current_sense,
  output logic main_gate_drive,
  output logic fast_off_source,
  output logic fast_off_sink,
  output logic hold_stage
);
  // ==========================================
  // state and counters
  ccs_state_t st_q, st_d;
  logic [TW-1:0] low_q;
  logic [TW-1:0] stage_q;
  logic [TW-1:0] sink_q;
  logic sink_act_q;
  logic supply_ok_q;
  logic gate_q, src_q, snk_q, hold_q;
  ccs_pwm_if pif ();

  // ==========================================
  // decode
  wire uv_hit = (low_q >= TW'(UV_N) - TW'(1)) && below_release_level;
  wire fs_hit = (low_q >= TW'(FS_DET_N) - TW'(1)) && below_release_level;
  wire stage_done = (stage_q >= TW'(STAGE_N) - TW'(1));
  wire running = (st_q == CCS_ST_PICKUP) || (st_q == CCS_ST_HOLD);
  wire fs_trig = (st_q == CCS_ST_HOLD) && fs_hit;
  wire sink_done = (sink_q >= TW'(FS_SINK_N) - TW'(1));
  wire supply_ok_d = supply_off ? 1'b0 : (supply_on ? 1'b1 : supply_ok_q);
  wire start_ok = above_action_level && supply_ok_q;
  assign pif.run = running && supply_ok_q;
  assign pif.trip = (st_q == CCS_ST_HOLD) ? hold_current_sense :
                    pickup_current_sense;

  // ==========================================
  // next state
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      CCS_ST_IDLE: begin
        if (start_ok && !below_release_level)
          st_d = CCS_ST_PICKUP;
      end
      CCS_ST_PICKUP: begin
        if (uv_hit)
          st_d = CCS_ST_UV;
        else if (stage_done)
          st_d = CCS_ST_HOLD;
      end
      CCS_ST_HOLD: begin
        if (uv_hit)
          st_d = CCS_ST_UV;
      end
      CCS_ST_UV: begin
        st_d = CCS_ST_IDLE;
      end
      default: st_d = CCS_ST_IDLE;
    endcase
  end

  // ==========================================
  // registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= CCS_ST_IDLE;
      supply_ok_q <= 1'b0;
    end else begin
      st_q <= st_d;
      supply_ok_q <= supply_ok_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || !below_release_level)
      low_q <= '0;
    else if (low_q != {TW{1'b1}})
      low_q <= low_q + TW'(1);
  end

  always_ff @(posedge clk) begin
    if (!nrst || st_q != CCS_ST_PICKUP || uv_hit)
      stage_q <= '0;
    else if (!stage_done)
      stage_q <= stage_q + TW'(1);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sink_act_q <= 1'b0;
      sink_q <= '0;
    end else if (fs_trig && !sink_act_q && sink_q == '0) begin
      sink_act_q <= 1'b1;
    end else if (sink_act_q) begin
      sink_q <= sink_q + TW'(1);
      if (sink_done)
        sink_act_q <= 1'b0;
    end else if (st_q == CCS_ST_PICKUP) begin
      sink_q <= '0;
    end
  end

  // ==========================================
  // output flops
  always_ff @(posedge clk) begin
    if (!nrst) begin
      gate_q <= 1'b0;
      src_q <= 1'b0;
      snk_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      gate_q <= pif.gate_on && pif.run && !uv_hit;
      src_q <= pif.gate_on && pif.run && !uv_hit && !sink_act_q;
      snk_q <= sink_act_q && !sink_done;
      hold_q <= (st_q == CCS_ST_HOLD);
    end
  end
  assign main_gate_drive = gate_q;
  assign fast_off_source = src_q;
  assign fast_off_sink = snk_q;
  assign hold_stage = hold_q;

  // ==========================================
  // pwm timebase
  ccs_pwm u_pwm (
    .clk(clk),
    .nrst(nrst),
    .bus(pif.pwm)
  );
endmodule : ccs_seq
`default_nettype wire

// file: testbench/ccs_seq_checker.sv
// port checks for the coil stage sequencer
// assumes bound into ccs_seq, one clock
`timescale 1ns/100ps
`default_nettype none
module ccs_seq_checker #(
  parameter int unsigned UV_N = 40,
  parameter int unsigned FS_DET_N = 20,
  parameter int unsigned FS_SINK_N = 100
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic below_release_level,
  input wire logic supply_off,
  input wire logic pickup_current_sense,
  input wire logic hold_current_sense,
  input wire logic main_gate_drive,
  input wire logic fast_off_source,
  input wire logic fast_off_sink,
  input wire logic hold_stage
);
  // ==========
  // run counters
  int unsigned lo_q = 0;
  int unsigned sk_q = 0;
  int unsigned on_q = 0;
  always_ff @(posedge clk) begin
    lo_q <= (!nrst || !below_release_level) ? 0 : lo_q + 1;
    sk_q <= (!nrst || !fast_off_sink) ? 0 : sk_q + 1;
    on_q <= (!nrst || !main_gate_drive) ? 0 : on_q + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  rst_quiet_a: assert property ($rose(nrst) |-> !main_gate_drive
    && !fast_off_source && !fast_off_sink && !hold_stage) else $error("busy");
  supply_cut_a: assert property (supply_off [*4] |->
    !main_gate_drive) else $error("gate on without supply");
  src_gate_a: assert property (fast_off_source |-> main_gate_drive
    && !fast_off_sink) else $error("source outside on-time");
  src_follow_a: assert property (main_gate_drive && !fast_off_sink
    && !$past(fast_off_sink) |-> fast_off_source) else $error("no source");
  sink_arm_a: assert property ($rose(fast_off_sink) |->
    $past(hold_stage) && lo_q >= FS_DET_N - 2) else $error("early sink");
  sink_max_a: assert property (fast_off_sink |->
    sk_q <= FS_SINK_N + 1) else $error("sink too long");
  sink_min_a: assert property ($fell(fast_off_sink) |->
    sk_q >= FS_SINK_N - 1) else $error("sink too short");
  uv_off_a: assert property (lo_q >= UV_N + 3 |-> !main_gate_drive
    && !hold_stage) else $error("no undervoltage");
  hold_trip_a: assert property (hold_stage && hold_current_sense
    && on_q > 140 |-> ##[1:3] !main_gate_drive) else $error("hold trip");
  pick_trip_a: assert property (!hold_stage && pickup_current_sense
    && on_q > 140 |-> ##[1:3] !main_gate_drive) else $error("pick trip");
endmodule : ccs_seq_checker
bind ccs_seq ccs_seq_checker #(.UV_N(UV_N), .FS_DET_N(FS_DET_N),
  .FS_SINK_N(FS_SINK_N)) u_chk (.*);
`default_nettype wire

// file: testbench/ccs_coil_model.sv
// coil and sense resistor model, current ramps while gate on
// assumes gate from ccs_seq, trips hold level before pick-up level
`timescale 1ns/100ps
`default_nettype none
module ccs_coil_model #(
  parameter int unsigned PK = 400,
  parameter int unsigned HD = 200
) (
  input wire logic clk,
  input wire logic main_gate_drive,
  output logic pickup_current_sense,
  output logic hold_current_sense
);
  // ==========
  // coil current
  int unsigned i_q = 0;
  always_ff @(posedge clk) i_q <= main_gate_drive ? i_q + 1 : 0;
  assign pickup_current_sense = i_q >= PK;
  assign hold_current_sense = i_q >= HD;
endmodule : ccs_coil_model
`default_nettype wire

// file: testbench/ccs_seq_bench.sv
// self-checking bench for ccs_seq with coil model
// assumes ccs_pkg and design compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module ccs_seq_bench
  import ccs_pkg::*;
;
  localparam int unsigned UV = 40, FD = 20, ST = 15000, SK = 100;
  logic clk = 0, nrst = 0, above_action_level = 0, below_release_level = 1;
  logic supply_on = 0, supply_off = 0;
  wire logic pickup_current_sense, hold_current_sense, main_gate_drive;
  wire logic fast_off_source, fast_off_sink, hold_stage;
  wire logic [3:0] outs = {main_gate_drive, fast_off_source, fast_off_sink,
    hold_stage};
  int failures = 0, checked = 0, cyc_q = 0, n, f;
  bit g;
  always #2 clk = ~clk;
  ccs_seq #(.UV_N(UV), .FS_DET_N(FD), .STAGE_N(ST), .FS_SINK_N(SK)) u_dut (.*);
  ccs_coil_model u_coil (.*);
  // ==========
  // helpers
  function automatic bit in_win(input int v);
    return v >= ST && v <= ST + 3;
  endfunction : in_win
  function automatic int nom_per();
    return CLK_KHZ * 1000 / SW_FREQ_HZ;
  endfunction : nom_per
  function automatic bit per_ok(input int v);
    int span;
    span = nom_per() * JITTER_PERMIL / 2000;
    return v >= nom_per() - span && v <= nom_per() + span;
  endfunction : per_ok
  task automatic cy(input int k);
    repeat (k) @(negedge clk);
  endtask : cy
  task automatic lv(input bit a, input bit b);
    above_action_level = a;
    below_release_level = b;
  endtask : lv
  task automatic to_hold();
    n = 0;
    f = 0;
    g = 0;
    lv(1, 0);
    while (hold_stage !== 1'b1 && n < 20000) begin
      cy(1);
      n++;
      g |= main_gate_drive;
      if (f == 0 && main_gate_drive === 1'b1)
        f = n;
    end
  endtask : to_hold
  task automatic final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cyc_q++;
    if (cyc_q == 80000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    void'($urandom(32'h7e19b22f));
    cy(6);
    nrst = 1;
    cy(1);
    `CHK("outputs", 4'h0, outs)
    supply_on = 1;
    cy(200);
    `CHK("idle gate", 1'b0, main_gate_drive)
    to_hold();
    `CHK("stage time", 1'b1, in_win(n))
    `CHK("pickup gate", 1'b1, g)
    repeat (6) begin
      lv(0, 1);
      cy($urandom_range(FD - 4, 1));
      lv(1, 0);
      cy(3);
      `CHK("glitch sink", 1'b0, fast_off_sink)
    end
    lv(0, 1);
    cy(FD + 4);
    `CHK("sink on", 1'b1, fast_off_sink)
    `CHK("source off", 1'b0, fast_off_source)
    cy(UV);
    `CHK("uv state", 4'h2, outs)
    cy(SK);
    `CHK("sink end", 1'b0, fast_off_sink)
    lv(0, 0);
    cy(300);
    `CHK("rearm", 4'h0, outs)
    to_hold();
    `CHK("stage again", 1'b1, in_win(n))
    supply_off = 1;
    cy(4);
    g = 0;
    repeat (300) begin
      cy(1);
      g |= main_gate_drive;
    end
    `CHK("supply cut", 1'b0, g)
    supply_off = 0;
    lv(0, 1);
    cy(UV + SK + 10);
    lv(1, 0);
    cy(ST / 2);
    lv(0, 1);
    cy(UV + 4);
    `CHK("pickup uv", 4'h0, outs)
    to_hold();
    `CHK("timer cleared", 1'b1, in_win(n))
    while (main_gate_drive !== 1'b1 && n < 40000) begin
      cy(1);
      n++;
    end
    `CHK("period", 1'b1, per_ok(n - f))
    `CHK("dither", 1'b1, (n - f) != nom_per())
    final_report();
  end
endmodule : ccs_seq_bench
`default_nettype wire
